// ==== logic/plc_acc_pkg.sv ====
// Shared constants, types and decoding for the accumulator load/store datapath
package plc_acc_pkg;

	// Datapath widths
	localparam int DATA_W = 16;
	localparam int ACC_W = 32;
	localparam int ADDR_W = 16;
	localparam int CNT_W = 6;
	localparam int STACK_DEPTH = 8;

	// Reset values
	localparam logic [31:0] ACC_RESET = 32'h0000_0000;
	localparam logic [31:0] STACK_RESET = 32'h0000_0000;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic FLAG_RESET = 1'b0;

	// Bit-field store count limits
	localparam logic [5:0] BIT_CNT_MIN = 6'h01;
	localparam logic [5:0] BIT_CNT_MAX = 6'h20;

	// Field positions
	localparam int OCT_DIGITS = 6;
	localparam int HI_LSB = 16;

	// Operation codes from the sequencer
	typedef enum logic [3:0] {
		word_load_op = 4'h0,
		octal_address_load_op = 4'h1,
		word_store_op = 4'h2,
		double_store_op = 4'h3,
		bit_field_store_op = 4'h4,
		pop_op = 4'h5,
		and_op = 4'h6,
		double_and_op = 4'h7,
		or_op = 4'h8
	} op_code_t;

	// Sequencing states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_PTR_W = 3'b001,
		S_PTR_D = 3'b010,
		S_GO = 3'b011,
		S_WR2 = 3'b100,
		S_BITS = 3'b101,
		S_RD_W = 3'b110,
		S_RD_D = 3'b111
	} seq_state_t;

	// Octal digits held one per nibble, packed to their binary value
	function automatic logic [15:0] octal_to_bin(input logic [23:0] digits);
		logic [17:0] packed_v;
		packed_v = '0;
		for (int i = 0; i < OCT_DIGITS; i++) begin
			packed_v[3*i +: 3] = digits[4*i +: 3];
		end
		return packed_v[15:0];
	endfunction : octal_to_bin

	// Operations that only copy the accumulator out
	function automatic logic is_store(input op_code_t op);
		return (op == word_store_op) || (op == double_store_op) || (op == bit_field_store_op);
	endfunction : is_store

endpackage : plc_acc_pkg

// ==== logic/plc_accumulator_load_store_logic.sv ====
// Accumulator datapath: octal load, stores, stack pop, AND/OR and status flags
//
// Notes on behaviour
// - Octal address load converts to binary accumulator
// - Load-zero flag follows every load result
// - Load after load pushes old accumulator
// - Word store writes accumulator low word
// - Double store writes two consecutive words
// - Bit store copies 1-32 low bits
// - Pop moves stack top, shifts stack up
// - Pop updates result-zero flag
// - Single AND with memory word, low half
// - Single OR with memory word, low half
// - Logical ops update result-zero flag
// - Double AND with two words or constant
// - Double AND sets negative from bit 31
// - Flags hold until their own operation
// - Eight-deep stack, ninth push drops deepest
// - Pointer word contents give the address
// - Sixteen-bit load clears upper half
`timescale 1ns/1ps
module plc_accumulator_load_store_logic
	import plc_acc_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Issue port from the sequencer
	input wire logic op_valid,
	input wire op_code_t op_code,
	input wire logic [31:0] op_operand,
	input wire logic op_pointer,
	input wire logic op_constant,
	input wire logic [5:0] op_bit_count,
	output logic op_ready,
	// Word memory
	output logic mem_rd_en,
	output logic mem_wr_en,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wr_data,
	input wire logic [15:0] mem_rd_data,
	// Bit memory
	output logic bit_wr_en,
	output logic [15:0] bit_addr,
	output logic bit_wr_data,
	// Status
	output logic [31:0] acc_value,
	output logic load_zero_flag,
	output logic result_zero_flag,
	output logic result_negative_flag
);

	// Sequencer state and latched operation
	seq_state_t state_ff, nxt_state;
	op_code_t op_ff, nxt_op;
	logic [5:0] cnt_ff, nxt_cnt; // Bit count, clamped
	logic [5:0] idx_ff, nxt_idx; // Next bit to send
	logic [15:0] lo_ff, nxt_lo; // First word of a double read
	logic second_ff, nxt_second; // Second word pending
	logic ready_ff, nxt_ready;
	logic rd_ff, nxt_rd;
	logic wr_ff, nxt_wr;
	logic [15:0] addr_ff, nxt_addr;
	logic [15:0] wdata_ff, nxt_wdata;
	logic bwr_ff, nxt_bwr;
	logic [15:0] baddr_ff, nxt_baddr;
	logic bdata_ff, nxt_bdata;

	// Execution strobe handed to the datapath
	logic exec_en;
	op_code_t exec_op;
	logic [31:0] exec_val;
	logic accept;

	// Accumulator, stack and flags
	logic [31:0] acc_ff, nxt_acc;
	logic [31:0] stack_ff [DEPTH];
	logic [31:0] nxt_stack [DEPTH];
	logic pend_ff, nxt_pend; // Set by a load, cleared only by a store
	logic lz_ff, nxt_lz;
	logic rz_ff, nxt_rz;
	logic rn_ff, nxt_rn;

	assign accept = op_valid && ready_ff;

	// Sequencer next state: address resolution, memory traffic, execution
	always_comb begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_cnt = cnt_ff;
		nxt_idx = idx_ff;
		nxt_lo = lo_ff;
		nxt_second = second_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_baddr = baddr_ff;
		nxt_bdata = bdata_ff;
		nxt_rd = 1'b0;
		nxt_wr = 1'b0;
		nxt_bwr = 1'b0;
		exec_en = 1'b0;
		exec_op = op_ff;
		exec_val = ACC_RESET;
		case (state_ff)
			S_IDLE: begin
				if (accept) begin
					nxt_op = op_code;
					nxt_second = 1'b0;
					exec_op = op_code;
					// Out-of-range counts are clamped rather than refused
					if (op_bit_count < BIT_CNT_MIN) begin
						nxt_cnt = BIT_CNT_MIN;
					end else if (op_bit_count > BIT_CNT_MAX) begin
						nxt_cnt = BIT_CNT_MAX;
					end else begin
						nxt_cnt = op_bit_count;
					end
					if (op_code == octal_address_load_op) begin
						exec_en = 1'b1;
						exec_val = {16'h0000, octal_to_bin(op_operand[23:0])};
					end else if (op_code == pop_op) begin
						exec_en = 1'b1;
					end else if (op_code == word_load_op && op_constant) begin
						exec_en = 1'b1;
						exec_val = {16'h0000, op_operand[15:0]};
					end else if (op_code == double_and_op && op_constant) begin
						exec_en = 1'b1;
						exec_val = op_operand;
					end else if (op_code <= or_op) begin
						// Stores cancel load chaining as they are taken
						exec_en = is_store(op_code);
						nxt_addr = op_operand[15:0];
						if (op_pointer) begin
							nxt_rd = 1'b1;
							nxt_state = S_PTR_W;
						end else begin
							nxt_state = S_GO;
						end
					end
				end
			end
			S_PTR_W: begin
				nxt_state = S_PTR_D;
			end
			S_PTR_D: begin
				// Pointer contents taken as a plain binary address
				nxt_addr = mem_rd_data;
				nxt_state = S_GO;
			end
			S_GO: begin
				case (op_ff)
					word_store_op: begin
						nxt_wr = 1'b1;
						nxt_wdata = acc_ff[15:0];
						nxt_state = S_IDLE;
					end
					double_store_op: begin
						nxt_wr = 1'b1;
						nxt_wdata = acc_ff[15:0];
						nxt_state = S_WR2;
					end
					bit_field_store_op: begin
						nxt_idx = 6'h00;
						nxt_state = S_BITS;
					end
					default: begin
						nxt_rd = 1'b1;
						nxt_state = S_RD_W;
					end
				endcase
			end
			S_WR2: begin
				// High word goes to the following location
				nxt_wr = 1'b1;
				nxt_addr = addr_ff + 16'h0001;
				nxt_wdata = acc_ff[31:HI_LSB];
				nxt_state = S_IDLE;
			end
			S_BITS: begin
				nxt_bwr = 1'b1;
				nxt_baddr = addr_ff + {10'h000, idx_ff};
				nxt_bdata = acc_ff[idx_ff[4:0]];
				nxt_idx = idx_ff + 6'h01;
				if (nxt_idx == cnt_ff) begin
					nxt_state = S_IDLE;
				end
			end
			S_RD_W: begin
				nxt_state = S_RD_D;
			end
			S_RD_D: begin
				if (op_ff == double_and_op && !second_ff) begin
					// Low word first, then fetch the high word
					nxt_lo = mem_rd_data;
					nxt_second = 1'b1;
					nxt_addr = addr_ff + 16'h0001;
					nxt_rd = 1'b1;
					nxt_state = S_RD_W;
				end else begin
					exec_en = 1'b1;
					if (op_ff == double_and_op) begin
						exec_val = {mem_rd_data, lo_ff};
					end else begin
						exec_val = {16'h0000, mem_rd_data};
					end
					nxt_state = S_IDLE;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
		nxt_ready = (nxt_state == S_IDLE);
	end

	// Sequencer registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= S_IDLE;
			op_ff <= word_load_op;
			cnt_ff <= BIT_CNT_MIN;
			idx_ff <= 6'h00;
			lo_ff <= 16'h0000;
			second_ff <= 1'b0;
			ready_ff <= 1'b1;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			addr_ff <= ADDR_RESET;
			wdata_ff <= 16'h0000;
			bwr_ff <= 1'b0;
			baddr_ff <= ADDR_RESET;
			bdata_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			cnt_ff <= nxt_cnt;
			idx_ff <= nxt_idx;
			lo_ff <= nxt_lo;
			second_ff <= nxt_second;
			ready_ff <= nxt_ready;
			rd_ff <= nxt_rd;
			wr_ff <= nxt_wr;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			bwr_ff <= nxt_bwr;
			baddr_ff <= nxt_baddr;
			bdata_ff <= nxt_bdata;
		end
	end

	// Datapath next values; flags move only with their own operations
	always_comb begin
		nxt_acc = acc_ff;
		nxt_stack = stack_ff;
		nxt_pend = pend_ff;
		nxt_lz = lz_ff;
		nxt_rz = rz_ff;
		nxt_rn = rn_ff;
		if (exec_en) begin
			case (exec_op)
				word_load_op, octal_address_load_op: begin
					if (pend_ff) begin
						// Deepest entry falls off the end
						for (int i = DEPTH - 1; i > 0; i--) begin
							nxt_stack[i] = stack_ff[i - 1];
						end
						nxt_stack[0] = acc_ff;
					end
					nxt_acc = exec_val;
					nxt_lz = (exec_val == ACC_RESET);
					nxt_pend = 1'b1;
				end
				pop_op: begin
					for (int i = 0; i < DEPTH - 1; i++) begin
						nxt_stack[i] = stack_ff[i + 1];
					end
					nxt_stack[DEPTH - 1] = STACK_RESET;
					nxt_acc = stack_ff[0];
					nxt_rz = (stack_ff[0] == ACC_RESET);
				end
				and_op: begin
					nxt_acc = {16'h0000, acc_ff[15:0] & exec_val[15:0]};
					nxt_rz = ((acc_ff[15:0] & exec_val[15:0]) == 16'h0000);
				end
				or_op: begin
					nxt_acc = {16'h0000, acc_ff[15:0] | exec_val[15:0]};
					nxt_rz = ((acc_ff[15:0] | exec_val[15:0]) == 16'h0000);
				end
				double_and_op: begin
					nxt_acc = acc_ff & exec_val;
					nxt_rz = ((acc_ff & exec_val) == ACC_RESET);
					nxt_rn = acc_ff[31] & exec_val[31];
				end
				default: begin
					// Stores break the load-after-load chain
					nxt_pend = 1'b0;
				end
			endcase
		end
	end

	// Datapath registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			acc_ff <= ACC_RESET;
			for (int i = 0; i < DEPTH; i++) begin
				stack_ff[i] <= STACK_RESET;
			end
			pend_ff <= 1'b0;
			lz_ff <= FLAG_RESET;
			rz_ff <= FLAG_RESET;
			rn_ff <= FLAG_RESET;
		end else begin
			acc_ff <= nxt_acc;
			stack_ff <= nxt_stack;
			pend_ff <= nxt_pend;
			lz_ff <= nxt_lz;
			rz_ff <= nxt_rz;
			rn_ff <= nxt_rn;
		end
	end

	// Outputs straight from flip-flops
	assign op_ready = ready_ff;
	assign mem_rd_en = rd_ff;
	assign mem_wr_en = wr_ff;
	assign mem_addr = addr_ff;
	assign mem_wr_data = wdata_ff;
	assign bit_wr_en = bwr_ff;
	assign bit_addr = baddr_ff;
	assign bit_wr_data = bdata_ff;
	assign acc_value = acc_ff;
	assign load_zero_flag = lz_ff;
	assign result_zero_flag = rz_ff;
	assign result_negative_flag = rn_ff;

	// Checks on the datapath and the memory sequencing
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_take(op_code_t oc);
		accept && op_code == oc && !op_pointer && !op_constant;
	endsequence

	property p_octal_load;
		accept && op_code == octal_address_load_op
			|=> acc_ff == {16'h0000, octal_to_bin($past(op_operand[23:0]))} && lz_ff == (acc_ff == 0);
	endproperty
	a_octal_load: assert property (p_octal_load) else $error("octal load wrong");

	property p_load_push;
		exec_en && (exec_op == word_load_op || exec_op == octal_address_load_op) && pend_ff
			|=> stack_ff[0] == $past(acc_ff) && stack_ff[DEPTH - 1] == $past(stack_ff[DEPTH - 2]);
	endproperty
	a_load_push: assert property (p_load_push) else $error("load did not push");

	property p_word_store;
		s_take(word_store_op)
			|-> ##2 wr_ff && addr_ff == $past(op_operand[15:0], 2) && wdata_ff == acc_ff[15:0];
	endproperty
	a_word_store: assert property (p_word_store) else $error("word store wrong");

	sequence s_dbl_pair;
		wr_ff && wdata_ff == acc_ff[15:0] ##1 wr_ff && wdata_ff == acc_ff[31:16]
			&& addr_ff == $past(addr_ff) + 16'h0001;
	endsequence
	property p_double_store;
		s_take(double_store_op) |-> ##2 s_dbl_pair;
	endproperty
	a_double_store: assert property (p_double_store) else $error("double store wrong");

	property p_bit_store;
		bwr_ff |-> bdata_ff == acc_ff[5'(baddr_ff - addr_ff)] && (baddr_ff - addr_ff) < 16'h0020;
	endproperty
	a_bit_store: assert property (p_bit_store) else $error("bit store wrong");

	property p_pop;
		accept && op_code == pop_op
			|=> acc_ff == $past(stack_ff[0]) && stack_ff[0] == $past(stack_ff[1])
				&& rz_ff == (acc_ff == 0);
	endproperty
	a_pop: assert property (p_pop) else $error("pop wrong");

	property p_and_single;
		exec_en && exec_op == and_op
			|=> acc_ff[15:0] == ($past(acc_ff[15:0]) & $past(mem_rd_data)) && rz_ff == (acc_ff == 0);
	endproperty
	a_and_single: assert property (p_and_single) else $error("and wrong");

	property p_or_single;
		exec_en && exec_op == or_op
			|=> acc_ff[15:0] == ($past(acc_ff[15:0]) | $past(mem_rd_data)) && rz_ff == (acc_ff == 0);
	endproperty
	a_or_single: assert property (p_or_single) else $error("or wrong");

	property p_and_double;
		exec_en && exec_op == double_and_op
			|=> acc_ff == ($past(acc_ff) & $past(exec_val)) && rn_ff == acc_ff[31]
				&& rz_ff == (acc_ff == 0);
	endproperty
	a_and_double: assert property (p_and_double) else $error("double and wrong");

	property p_flag_hold;
		!(exec_en && (exec_op == word_load_op || exec_op == octal_address_load_op))
			|=> $stable(lz_ff);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("load flag moved");

	property p_pointer;
		state_ff == S_PTR_D |=> state_ff == S_GO && addr_ff == $past(mem_rd_data);
	endproperty
	a_pointer: assert property (p_pointer) else $error("pointer address wrong");

endmodule : plc_accumulator_load_store_logic

// ==== tb/acc_mem_model.sv ====
// Word and bit memory model on the far side of the accumulator datapath
`timescale 1ns/1ps
module acc_mem_model (
	// Clock
	input wire logic clk_sys,
	// Word memory port
	input wire logic mem_rd_en,
	input wire logic mem_wr_en,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wr_data,
	output logic [15:0] mem_rd_data,
	// Bit memory port
	input wire logic bit_wr_en,
	input wire logic [15:0] bit_addr,
	input wire logic bit_wr_data
);
	logic [15:0] words [0:255]; // Word store, low address bits only
	logic bits [0:255]; // Discrete store, preset high to expose writes
	logic [1:0] hold_cnt = 2'h0; // Cycles left in the read window
	// Fill memories at time zero
	initial begin
		for (int i = 0; i < 256; i++) begin
			words[i] = 16'h0000;
			bits[i] = 1'b1;
		end
	end
	// Read data held two cycles, then inverted every cycle so stale data matches only on alternate cycles
	always @(posedge clk_sys) begin
		if (mem_rd_en) begin
			mem_rd_data <= words[mem_addr[7:0]];
			hold_cnt <= 2'h2;
		end else begin
			hold_cnt <= (hold_cnt == 2'h0) ? 2'h0 : hold_cnt - 2'h1;
			if (hold_cnt != 2'h2) begin
				mem_rd_data <= ~mem_rd_data;
			end
		end
	end
	// Writes land on the strobe edge
	always @(posedge clk_sys) begin
		if (mem_wr_en) begin
			words[mem_addr[7:0]] <= mem_wr_data;
		end
		if (bit_wr_en) begin
			bits[bit_addr[7:0]] <= bit_wr_data;
		end
	end
endmodule : acc_mem_model

// ==== tb/plc_accumulator_load_store_logic_bench.sv ====
// Self-checking bench for the accumulator load/store datapath
`timescale 1ns/1ps
module plc_accumulator_load_store_logic_bench
	import plc_acc_pkg::*;
;
	// Clock, reset and sequencer side
	logic clk_sys = 1'b0;
	logic rst_b;
	logic op_valid;
	op_code_t op_code;
	logic [31:0] op_operand;
	logic op_pointer;
	logic op_constant;
	logic [5:0] op_bit_count;
	logic op_ready;
	// Memory side
	logic mem_rd_en;
	logic mem_wr_en;
	logic [15:0] mem_addr;
	logic [15:0] mem_wr_data;
	logic [15:0] mem_rd_data;
	logic bit_wr_en;
	logic [15:0] bit_addr;
	logic bit_wr_data;
	// Status
	logic [31:0] acc_value;
	logic load_zero_flag;
	logic result_zero_flag;
	logic result_negative_flag;
	// Bookkeeping
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [15:0] pat = 16'hA5C3; // Pattern for the bit store

	always #5 clk_sys = ~clk_sys;

	plc_accumulator_load_store_logic dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.op_valid(op_valid), .op_code(op_code), .op_operand(op_operand),
		.op_pointer(op_pointer), .op_constant(op_constant),
		.op_bit_count(op_bit_count), .op_ready(op_ready), .mem_rd_en(mem_rd_en),
		.mem_wr_en(mem_wr_en), .mem_addr(mem_addr), .mem_wr_data(mem_wr_data),
		.mem_rd_data(mem_rd_data), .bit_wr_en(bit_wr_en), .bit_addr(bit_addr),
		.bit_wr_data(bit_wr_data), .acc_value(acc_value),
		.load_zero_flag(load_zero_flag), .result_zero_flag(result_zero_flag),
		.result_negative_flag(result_negative_flag));

	acc_mem_model u_mem (.clk_sys(clk_sys), .mem_rd_en(mem_rd_en),
		.mem_wr_en(mem_wr_en), .mem_addr(mem_addr), .mem_wr_data(mem_wr_data),
		.mem_rd_data(mem_rd_data), .bit_wr_en(bit_wr_en), .bit_addr(bit_addr),
		.bit_wr_data(bit_wr_data));

	// Verdict and end of run
	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	// 32-bit comparison
	task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val

	// Single-bit comparison
	task automatic chk_bit(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	// One sequencer issue; the trailing idle cycle lets stores land
	task automatic issue(input op_code_t op, input logic [31:0] opnd, input logic ptr,
		input logic cst, input logic [5:0] cnt);
		int n;
		op_valid = 1'b1;
		op_code = op;
		op_operand = opnd;
		op_pointer = ptr;
		op_constant = cst;
		op_bit_count = cnt;
		@(posedge clk_sys);
		@(negedge clk_sys);
		op_valid = 1'b0;
		n = 0;
		while (op_ready !== 1'b1 && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
	endtask : issue

	// Constant word load
	task automatic ld(input logic [15:0] v);
		issue(word_load_op, {16'h0000, v}, 1'b0, 1'b1, 6'h00);
	endtask : ld

	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			stop_test();
		end
	end

	// Main sequence
	initial begin
		op_valid = 1'b0;
		op_code = word_load_op;
		op_operand = 32'h0000_0000;
		op_pointer = 1'b0;
		op_constant = 1'b0;
		op_bit_count = 6'h00;
		rst_b = 1'b0;
		// Presets wait for the model's own time-zero fill to finish first
		repeat (4) @(negedge clk_sys);
		u_mem.words[8'h20] = 16'h0030;
		u_mem.words[8'h22] = 16'h0060;
		u_mem.words[8'h41] = 16'hAAAA;
		u_mem.words[8'h60] = 16'h3C3C;
		u_mem.words[8'h61] = 16'hF00F;
		u_mem.words[8'h62] = 16'h8001;
		u_mem.words[8'h70] = 16'h7FFF;
		u_mem.words[8'h71] = 16'hFFFF;
		rst_b = 1'b1;
		chk_val("acc after reset", 32'h0000_0000, acc_value);
		chk_bit("ready after reset", 1'b1, op_ready);
		// Octal loads chain onto the stack
		issue(octal_address_load_op, 32'h0004_0400, 1'b0, 1'b0, 6'h00);
		chk_val("octal 40400", 32'h0000_4100, acc_value);
		chk_bit("load zero clear", 1'b0, load_zero_flag);
		issue(octal_address_load_op, 32'h0017_7777, 1'b0, 1'b0, 6'h00);
		chk_val("octal 177777", 32'h0000_FFFF, acc_value);
		issue(octal_address_load_op, 32'h0000_0000, 1'b0, 1'b0, 6'h00);
		chk_bit("load zero set", 1'b1, load_zero_flag);
		issue(pop_op, 32'h0000_0000, 1'b0, 1'b0, 6'h00);
		chk_val("pop first", 32'h0000_FFFF, acc_value);
		chk_bit("pop nonzero", 1'b0, result_zero_flag);
		chk_bit("load zero held", 1'b1, load_zero_flag);
		issue(pop_op, 32'h0000_0000, 1'b0, 1'b0, 6'h00);
		chk_val("pop second", 32'h0000_4100, acc_value);
		// Stores: direct, pointer, double
		ld(16'h1234);
		issue(word_store_op, 32'h0000_0010, 1'b0, 1'b0, 6'h00);
		chk_val("word store", 32'h0000_1234, {16'h0000, u_mem.words[8'h10]});
		issue(word_store_op, 32'h0000_0020, 1'b1, 1'b0, 6'h00);
		chk_val("pointer store", 32'h0000_1234, {16'h0000, u_mem.words[8'h30]});
		issue(double_store_op, 32'h0000_0040, 1'b0, 1'b0, 6'h00);
		chk_val("double low", 32'h0000_1234, {16'h0000, u_mem.words[8'h40]});
		chk_val("double high", 32'h0000_0000, {16'h0000, u_mem.words[8'h41]});
		// Ten loads overflow the eight-level stack
		for (int i = 1; i <= 10; i++) begin
			ld(i[15:0]);
		end
		for (int i = 9; i >= 2; i--) begin
			issue(pop_op, 32'h0000_0000, 1'b0, 1'b0, 6'h00);
			chk_val("stack pop", i, acc_value);
		end
		issue(pop_op, 32'h0000_0000, 1'b0, 1'b0, 6'h00);
		chk_val("dropped entry", 32'h0000_0000, acc_value);
		chk_bit("pop zero", 1'b1, result_zero_flag);
		// Bit stores at both count limits
		ld(pat);
		issue(bit_field_store_op, 32'h0000_0050, 1'b0, 1'b0, 6'h20);
		for (int i = 0; i < 32; i++) begin
			chk_bit("bit store", (i < 16) ? pat[i] : 1'b0, u_mem.bits[8'h50 + i]);
		end
		ld(16'h0002);
		issue(bit_field_store_op, 32'h0000_0090, 1'b0, 1'b0, 6'h01);
		chk_bit("single bit", 1'b0, u_mem.bits[8'h90]);
		chk_bit("bit past count", 1'b1, u_mem.bits[8'h91]);
		// A zero count still sends one bit
		issue(bit_field_store_op, 32'h0000_00A0, 1'b0, 1'b0, 6'h00);
		chk_bit("count zero bit", 1'b0, u_mem.bits[8'hA0]);
		chk_bit("count zero extra", 1'b1, u_mem.bits[8'hA1]);
		// Logical operations and their flags
		ld(16'h0FF0);
		issue(and_op, 32'h0000_0060, 1'b0, 1'b0, 6'h00);
		chk_val("and", 32'h0000_0C30, acc_value);
		chk_bit("and nonzero", 1'b0, result_zero_flag);
		issue(and_op, 32'h0000_0061, 1'b0, 1'b0, 6'h00);
		chk_bit("and zero", 1'b1, result_zero_flag);
		chk_bit("load zero kept", 1'b0, load_zero_flag);
		issue(or_op, 32'h0000_0062, 1'b0, 1'b0, 6'h00);
		chk_val("or", 32'h0000_8001, acc_value);
		chk_bit("or nonzero", 1'b0, result_zero_flag);
		issue(double_and_op, 32'h0000_80F0, 1'b0, 1'b1, 6'h00);
		chk_val("double and const", 32'h0000_8000, acc_value);
		chk_bit("negative clear", 1'b0, result_negative_flag);
		issue(double_and_op, 32'h0000_0070, 1'b0, 1'b0, 6'h00);
		chk_val("double and mem", 32'h0000_0000, acc_value);
		chk_bit("double and zero", 1'b1, result_zero_flag);
		ld(16'hFFFF);
		issue(and_op, 32'h0000_0022, 1'b1, 1'b0, 6'h00);
		chk_val("pointer and", 32'h0000_3C3C, acc_value);
		// Word load from memory chains onto the stack
		issue(word_load_op, 32'h0000_0010, 1'b0, 1'b0, 6'h00);
		chk_val("memory load", 32'h0000_1234, acc_value);
		chk_bit("memory load nonzero", 1'b0, load_zero_flag);
		issue(pop_op, 32'h0000_0000, 1'b0, 1'b0, 6'h00);
		chk_val("pop after memory load", 32'h0000_3C3C, acc_value);
		stop_test();
	end
endmodule : plc_accumulator_load_store_logic_bench
